// file: serial_adc_control_sequencer.sv
// control and serial port of a 12-bit converter with 8-input selector
// assumes: core_clk free running, sclk from the host (may stop between
// frames), aclk and cs_n are asynchronous pins, conv_data comes from the
// analog successive-approximation core and is stable at conversion end
//
// Functional notes
// - output word is 8, 12 or 16 bits long as configured
// - result leaves msb first or lsb first as configured
// - unipolar gives 12-bit result, bipolar 11 bits plus sign
// - bipolar results are coded in two's complement automatically
// - eight single-ended inputs, four differential pairs, mixed freely
// - host-selected power shutdown entered while idle
// - full duplex: config in on din while result goes out on dout
// - dout enabled on second conversion clock fall after cs falls
// - selected input sampled for seven shift clock cycles
// - conversion lasts 52 conversion clocks; host keeps cs high meanwhile
// - dout changes after each falling shift clock edge
// - control inputs ignored until two conversion clock falls after cs
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_map.svh"

module serial_adc_control_sequencer (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  input wire logic aclk,
  input wire logic [11:0] conv_data,
  output logic dout,
  output logic dout_oe_n,
  output logic sample_hold,
  output logic [2:0] mux_pos,
  output logic [2:0] mux_neg,
  output logic mux_neg_com,
  output logic conv_busy,
  output logic power_down
);

  //////////////////////////////////////////////////////////////////////
  // core domain state

  adc_seq_pkg::core_t q;
  adc_seq_pkg::core_t n;
  adc_seq_pkg::link_rise_t r;
  adc_seq_pkg::link_rise_t nr;
  adc_seq_pkg::link_fall_t f;
  adc_seq_pkg::link_fall_t nf;

  logic afall;
  logic link_clr;
  logic [11:0] res;
  logic [11:0] rev;
  logic [15:0] mask;

  assign afall = q.ac_s3 & ~q.ac_s2;
  // link logic is held cleared outside the enabled part of a frame
  assign link_clr = q.hold;

  always_comb begin
    n = q;
    res = q.uni ? q.cd_s2 : {~q.cd_s2[11], q.cd_s2[10:0]};
    rev = {<<{res}};
    if (q.wl == `WL_8) begin
      mask = `MASK_8;
    end else if (q.wl == `WL_12) begin
      mask = `MASK_12;
    end else begin
      mask = `MASK_16;
    end
    n.cs_s1 = cs_n;
    n.cs_s2 = q.cs_s1;
    n.ac_s1 = aclk;
    n.ac_s2 = q.ac_s1;
    n.ac_s3 = q.ac_s2;
    n.cd_s1 = conv_data;
    n.cd_s2 = q.cd_s1;
    case (q.st)
      adc_seq_pkg::ST_IDLE: begin
        n.hold = 1'b1;
        n.oe_n = 1'b1;
        if (!q.cs_s2) begin
          n.st = adc_seq_pkg::ST_WAIT_EN;
          n.en_cnt = 2'h0;
          n.pwr_dn = 1'b0;
        end
      end
      adc_seq_pkg::ST_WAIT_EN: begin
        if (q.cs_s2) begin
          n.st = adc_seq_pkg::ST_IDLE;
        end else if (afall) begin
          n.en_cnt = q.en_cnt + 2'h1;
          // host keeps sclk still until here, so no bit is lost
          if (q.en_cnt == `ACCESS_FALLS - 2'h1) begin
            n.hold = 1'b0;
            n.oe_n = 1'b0;
            n.st = adc_seq_pkg::ST_FRAME;
          end
        end
      end
      adc_seq_pkg::ST_FRAME: begin
        if (q.cs_s2) begin
          n.hold = 1'b1;
          n.oe_n = 1'b1;
          // sclk is quiet once cs is high, so cfg is stable to read here
          n.uni = r.cfg[`CFG_UNI];
          n.msbf = r.cfg[`CFG_MSBF];
          n.wl = r.cfg[`CFG_WL_HI:`CFG_WL_LO];
          if (r.cfg[`CFG_WL_HI:`CFG_WL_LO] == `WL_OFF) begin
            n.pwr_dn = 1'b1;
            n.st = adc_seq_pkg::ST_IDLE;
          end else begin
            n.busy = 1'b1;
            n.conv_cnt = 6'h00;
            n.st = adc_seq_pkg::ST_CONV;
          end
        end
      end
      adc_seq_pkg::ST_CONV: begin
        if (afall) begin
          n.conv_cnt = q.conv_cnt + 6'h01;
          if (q.conv_cnt == `CONV_FALLS - 6'h01) begin
            n.busy = 1'b0;
            n.seq = (q.msbf ? {4'h0, rev} : {4'h0, res}) & mask;
            n.st = adc_seq_pkg::ST_IDLE;
          end
        end
      end
      default: begin
        n.st = adc_seq_pkg::ST_IDLE;
      end
    endcase
    if (srst) begin
      n = '0;
      n.cs_s1 = 1'b1;
      n.cs_s2 = 1'b1;
      n.st = adc_seq_pkg::ST_IDLE;
      n.hold = 1'b1;
      n.oe_n = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    q <= n;
  end

  //////////////////////////////////////////////////////////////////////
  // link domain, rising shift clock: config in, selector, sampling

  always_comb begin
    nr = r;
    if (r.rise_cnt < `CFG_BITS) begin
      nr.cfg = {r.cfg[6:0], din};
    end
    if (r.rise_cnt != `RISE_SAT) begin
      nr.rise_cnt = r.rise_cnt + 4'h1;
    end
    if (r.rise_cnt == `SAMPLE_FIRST) begin
      nr.sample = 1'b1;
      nr.com = r.cfg[`CFG_SGL - 1];
      nr.pos = {r.cfg[`CFG_SEL_HI - 1:0], din, r.cfg[`CFG_ODD - 1]};
      nr.neg = {r.cfg[`CFG_SEL_HI - 1:0], din, ~r.cfg[`CFG_ODD - 1]};
    end else if (r.rise_cnt == `SAMPLE_LAST) begin
      nr.sample = 1'b0;
    end
  end

  always_ff @(posedge sclk or posedge link_clr) begin
    if (link_clr) begin
      r <= '0;
    end else begin
      r <= nr;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // link domain, falling shift clock: result out

  // seq only changes during conversion, when the host keeps sclk still
  always_comb begin
    nf = f;
    if (f.idx < `OUT_BITS) begin
      nf.dout = q.seq[f.idx[3:0]];
      nf.idx = f.idx + 5'h01;
    end else begin
      nf.dout = 1'b0;
    end
  end

  always_ff @(negedge sclk or posedge link_clr) begin
    if (link_clr) begin
      f <= '0;
    end else begin
      f <= nf;
    end
  end

  assign dout = f.dout;
  assign dout_oe_n = q.oe_n;
  assign sample_hold = r.sample;
  assign mux_pos = r.pos;
  assign mux_neg = r.neg;
  assign mux_neg_com = r.com;
  assign conv_busy = q.busy;
  assign power_down = q.pwr_dn;

  //////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  sequence s_access_done;
    $past(q.st == adc_seq_pkg::ST_WAIT_EN) && $past(afall) &&
      $past(q.en_cnt) == 2'h1;
  endsequence

  enable_on_second_a: assert property (
    $fell(dout_oe_n) |-> s_access_done)
    else $error("dout enabled away from second aclk fall");

  hold_release_a: assert property (
    $fell(q.hold) |-> s_access_done)
    else $error("control inputs released too early");

  hiz_on_cs_a: assert property (
    (q.st == adc_seq_pkg::ST_FRAME) && q.cs_s2 |=> dout_oe_n ##1 q.hold)
    else $error("dout not released after cs rose");

  conv_length_a: assert property (
    $fell(conv_busy) |-> $past(q.conv_cnt) == 6'h33 && $past(afall))
    else $error("conversion not 52 aclk cycles");

  bipolar_code_a: assert property (
    $fell(conv_busy) && !q.uni && q.msbf |->
      q.seq[0] == !$past(q.cd_s2[11]))
    else $error("bipolar sign not two's complement");

  bit_order_a: assert property (
    $fell(conv_busy) && q.msbf && q.uni |->
      q.seq[0] == $past(q.cd_s2[11]) && q.seq[7] == $past(q.cd_s2[4]) &&
      (q.wl == `WL_8 || q.seq[11] == $past(q.cd_s2[0])))
    else $error("msb first order wrong");

  word_length_a: assert property (
    $fell(conv_busy) |->
      (q.wl == `WL_8 && q.seq[15:8] == 8'h00) ||
      (q.wl == `WL_12 && q.seq[15:12] == 4'h0) || q.wl == `WL_16)
    else $error("word length padding wrong");

  shutdown_idle_a: assert property (
    power_down |-> q.st != adc_seq_pkg::ST_CONV && !conv_busy)
    else $error("shutdown outside idle");

  sequence s_window;
    sample_hold [*7] ##1 !sample_hold;
  endsequence

  sample_window_a: assert property (
    @(posedge sclk) disable iff (link_clr)
    $rose(sample_hold) |-> s_window)
    else $error("sample window not seven sclk cycles");

  config_shift_a: assert property (
    @(posedge sclk) disable iff (link_clr)
    r.rise_cnt < `CFG_BITS |=> r.cfg[0] == $past(din))
    else $error("din not captured on sclk rise");

  diff_pair_a: assert property (
    @(posedge sclk) disable iff (link_clr)
    sample_hold |-> mux_neg == {mux_pos[2:1], ~mux_pos[0]})
    else $error("differential pair mismatched");

  dout_step_a: assert property (
    @(negedge sclk) disable iff (link_clr)
    f.idx < `OUT_BITS |=> f.idx == $past(f.idx) + 5'h01)
    else $error("dout not stepped on sclk fall");

endmodule

`default_nettype wire

// file: adc_seq_map.svh
// constants for the serial converter control sequencer
// assumes: included by bare name after the package that holds the types
`ifndef ADC_SEQ_MAP_SVH
`define ADC_SEQ_MAP_SVH

// configuration word, first bit in ends up at the top
`define CFG_BITS 4'h8
`define CFG_SGL 3
`define CFG_ODD 2
`define CFG_SEL_HI 1
`define CFG_SEL_LO 0
`define CFG_UNI 3
`define CFG_MSBF 2
`define CFG_WL_HI 1
`define CFG_WL_LO 0

// word length codes
`define WL_OFF 2'h0
`define WL_8 2'h1
`define WL_12 2'h2
`define WL_16 2'h3
`define MASK_8 16'h00ff
`define MASK_12 16'h0fff
`define MASK_16 16'hffff

// timing in conversion clock falls and shift clock rises and falls
`define ACCESS_FALLS 2'h2
`define CONV_FALLS 6'h34
`define SAMPLE_FIRST 4'h3
`define SAMPLE_LAST 4'ha
`define RISE_SAT 4'hf
`define OUT_BITS 5'h10

`endif

// file: adc_seq_pkg.sv
// types for the serial converter control sequencer
// assumes: nothing; compiled before the sequencer module
package adc_seq_pkg;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT_EN,
    ST_FRAME,
    ST_CONV
  } seq_state_t;

  typedef struct packed {
    logic cs_s1;
    logic cs_s2;
    logic ac_s1;
    logic ac_s2;
    logic ac_s3;
    logic [11:0] cd_s1;
    logic [11:0] cd_s2;
    seq_state_t st;
    logic [1:0] en_cnt;
    logic [5:0] conv_cnt;
    logic hold;
    logic oe_n;
    logic pwr_dn;
    logic busy;
    logic uni;
    logic msbf;
    logic [1:0] wl;
    logic [15:0] seq;
  } core_t;

  typedef struct packed {
    logic [3:0] rise_cnt;
    logic [7:0] cfg;
    logic sample;
    logic [2:0] pos;
    logic [2:0] neg;
    logic com;
  } link_rise_t;

  typedef struct packed {
    logic [4:0] idx;
    logic dout;
  } link_fall_t;

endpackage

// file: host_port_model.sv
// host serial port model: drives select, shift clock and data in
// assumes: aclk free running; the bench calls frame() one at a time
`timescale 1ns/1ps
`default_nettype none
module host_port_model (
  input wire logic aclk,
  input wire logic dout,
  input wire logic dout_oe_n,
  output var logic cs_n,
  output var logic sclk,
  output var logic din
);
  // released line reads back inverted so a stray sample cannot pass
  wire pin = dout_oe_n ? ~dout : dout;
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    din = 1'b0;
  end
  task automatic frame(input logic [7:0] c, input bit early,
                       output logic [15:0] rx);
    rx = 16'h0000;
    @(negedge aclk);
    #1 cs_n = 1'b0;
    // stray edge while the port is still locked out
    if (early) begin
      din = 1'b1;
      #30 sclk = 1'b1;
      #24 sclk = 1'b0;
    end
    repeat (2) @(negedge aclk);
    #200;
    for (int k = 0; k < 17; k++) begin
      din = (k < 8) ? c[7-k] : ~din;
      #24;
      if (k > 0) rx[16-k] = pin;
      sclk = 1'b1;
      #24 sclk = 1'b0;
    end
    #24;
    @(negedge aclk);
    #1 cs_n = 1'b1;
    din = ~din;
    repeat (56) @(negedge aclk);
  endtask
endmodule
`default_nettype wire

// file: test_serial_adc_control_sequencer.sv
// self-checking bench for the converter control sequencer
// assumes: host_port_model drives the serial pins
`timescale 1ns/1ps
`default_nettype none
module test_serial_adc_control_sequencer;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic aclk = 1'b0;
  logic [11:0] conv_data = 12'h000;
  wire sclk;
  wire cs_n;
  wire din;
  logic dout, dout_oe_n, sample_hold, mux_neg_com, conv_busy, power_down;
  logic [2:0] mux_pos, mux_neg;
  logic [11:0] last = 12'h000;
  logic [15:0] rx;
  logic [7:0] c;
  int fails = 0;
  int n_checks = 0;
  initial forever #5 core_clk = ~core_clk;
  initial begin
    #3;
    forever #40 aclk = ~aclk;
  end
  serial_adc_control_sequencer dut (.core_clk(core_clk), .srst(srst),
    .sclk(sclk), .cs_n(cs_n), .din(din), .aclk(aclk),
    .conv_data(conv_data), .dout(dout), .dout_oe_n(dout_oe_n),
    .sample_hold(sample_hold), .mux_pos(mux_pos), .mux_neg(mux_neg),
    .mux_neg_com(mux_neg_com), .conv_busy(conv_busy),
    .power_down(power_down));
  host_port_model host (.aclk(aclk), .dout(dout), .dout_oe_n(dout_oe_n),
    .cs_n(cs_n), .sclk(sclk), .din(din));
  //////////////////////////////////////////////////////////////////////
  task chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    n_checks++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %s exp %h seen %h", nm, e, s);
    end
  endtask
  task end_sim;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  function automatic logic [15:0] exp_word(input logic [7:0] cf,
                                           input logic [11:0] d);
    logic [11:0] w;
    logic [15:0] e;
    int n;
    w = cf[3] ? d : {~d[11], d[10:0]};
    n = 4 + 4 * int'(cf[1:0]);
    e = 16'h0000;
    for (int i = 0; i < 12 && i < n; i++) e[15-i] = cf[2] ? w[11-i] : w[i];
    return e;
  endfunction
  int cs_falls = 0;
  int cs_rises = 0;
  int sclk_rises = 0;
  always @(negedge cs_n) cs_falls++;
  always @(posedge cs_n) cs_rises++;
  always @(posedge sclk) sclk_rises++;
  // polled on core_clk so a stuck host cannot hang the bench
  task automatic wait_cnt(input int sel, input int goal);
    int k;
    k = 0;
    while (k < 2000 && ((sel == 0 && cs_falls < goal) ||
           (sel == 1 && cs_rises < goal) ||
           (sel == 2 && sclk_rises < goal))) begin
      @(posedge core_clk);
      k++;
    end
    if (k == 2000) begin
      fails++;
      $display("[ERR] wait %0d exp %0d seen timeout", sel, goal);
    end
  endtask
  // timing and selector watch running beside one frame
  task automatic watch(input logic [7:0] cf);
    int sh;
    int n;
    int bf;
    int br;
    int bs;
    sh = 0;
    n = 0;
    bf = cs_falls;
    br = cs_rises;
    wait_cnt(0, bf + 1);
    @(negedge aclk);
    #60 chk("oe_early", 16'(dout_oe_n), 16'h0001);
    @(negedge aclk);
    #60 chk("oe_on", 16'(dout_oe_n), 16'h0000);
    chk("pd_clr", 16'(power_down), 16'h0000);
    bs = sclk_rises;
    for (int j = 1; j <= 17; j++) begin
      wait_cnt(2, bs + j);
      #1 sh += int'(sample_hold);
      if (j == 8) begin
        chk("pos", 16'(mux_pos), 16'({cf[5:4], cf[6]}));
        chk("com", 16'(mux_neg_com), 16'(cf[7]));
        if (!cf[7]) chk("neg", 16'(mux_neg), 16'({cf[5:4], ~cf[6]}));
      end
    end
    chk("smpl", 16'(sh), 16'h0007);
    wait_cnt(1, br + 1);
    #60 chk("oe_off", 16'(dout_oe_n), 16'h0001);
    chk("pd", 16'(power_down), 16'(cf[1:0] == 2'h0));
    n = 0;
    do begin
      @(negedge aclk);
      #60 n++;
    end while (conv_busy === 1'b1 && n < 100);
    chk("conv", 16'(n), (cf[1:0] != 2'h0) ? 16'h0034 : 16'h0001);
  endtask
  task automatic run(input logic [7:0] cf, input bit early, input bit cmp);
    logic [15:0] e;
    @(posedge core_clk);
    #1 conv_data = 12'($urandom);
    e = exp_word(cf, last);
    fork
      watch(cf);
      host.frame(cf, early, rx);
    join
    if (cmp) chk("word", rx, e);
    if (cf[1:0] != 2'h0) last = conv_data;
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(47363));
    repeat (2) @(posedge core_clk);
    #1 srst = 1'b0;
    // each length, order and coding; result shows in the next frame
    for (int i = 0; i < 12; i++) begin
      c[7:4] = 4'($urandom);
      c[3] = 1'(i / 6);
      c[2] = 1'((i / 3) % 2);
      c[1:0] = 2'(i % 3 + 1);
      run(c, 1'b0, 1'b0);
      run(c, 1'(i % 2), 1'b1);
    end
    // shutdown frame keeps the earlier result
    c[1:0] = 2'h0;
    run(c, 1'b0, 1'b0);
    c[1:0] = 2'h3;
    run(c, 1'b0, 1'b1);
    end_sim;
  end
  initial begin
    #1000000;
    fails++;
    end_sim;
  end
endmodule
`default_nettype wire
